// >>> msi_pkg.sv
// Purpose : Constants shared by the maintenance signal insert block
// Assumes : One DS3 (28 DS1) and one STS-1 (28 VT1.5) port per instance
// Notes   : Overhead bit numbers follow telecom order, bit 1 is the MSB
//
// Functional notes
// (RULE1) Unconnected DS1 outputs send all-ones idle
// (RULE2) Provisioned DS3 idle when all 28 idle
// (RULE3) Input failure replaces output with matching AIS
// (RULE4) DS3 LOS, OOF or AIS forces DS1 AIS
// (RULE5) Test input broadcast to chosen DS1 outputs
// (RULE6) Overlay AIS or test keeping cross-connection
// (RULE7) DS3 AIS or idle suppresses failure alarms
// (RULE8) DS3 AIS or idle raises status indication
// (RULE9) Report framed-1010 or unframed DS3 AIS
// (RULE10) Line AIS when K2 bits 6-8 ones
// (RULE11) Line AIS after five consecutive frames
// (RULE12) Line AIS detected only, never sent
// (RULE13) Path AIS sets H1-H3 and SPE ones
// (RULE14) STS-1 failures send AIS on all VTs
// (RULE15) VT loss of pointer sends that VT AIS
// (RULE16) VT path AIS sets V1-V4, SPE ones
// (RULE17) DS1 AIS from DS1, DS3 or VT failures
// (RULE18) STS-1 yellow is G1 bit 5 set
// (RULE19) VT yellow is V5 bit 8 set
// (RULE20) DS1 yellow only on monitored ports
// (RULE21) Provisioning bits reset to disabled
package msi_pkg;
    // ==========================================================
    // Sizes
    localparam int          MSI_NTRIB      = 28;
    localparam int          MSI_AISL_FRAMES = 5;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0]  MSI_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  MSI_OFF_TSEL   = 8'h04;
    localparam logic [7:0]  MSI_OFF_OVAIS  = 8'h08;
    localparam logic [7:0]  MSI_OFF_OVTST  = 8'h0C;
    localparam logic [7:0]  MSI_OFF_PMEN   = 8'h10;
    localparam logic [7:0]  MSI_OFF_SRCSTS = 8'h14;
    localparam logic [7:0]  MSI_OFF_STAT   = 8'h18;
    localparam logic [7:0]  MSI_OFF_EVT    = 8'h1C;
    localparam logic [7:0]  MSI_OFF_VTYEL  = 8'h20;
    localparam logic [7:0]  MSI_OFF_D1YEL  = 8'h24;
    // ==========================================================
    // Field positions
    localparam int          MSI_CTRL_IDLE_EN = 0;
    localparam int          MSI_ST_DS3_AIS   = 0;
    localparam int          MSI_ST_DS3_IDLE  = 1;
    localparam int          MSI_ST_AIS_FRM   = 2;
    localparam int          MSI_ST_AIS_UNF   = 3;
    localparam int          MSI_ST_AISL      = 4;
    localparam int          MSI_ST_STS_YEL   = 5;
    localparam int          MSI_ST_SEND_IDLE = 6;
    localparam int          MSI_NST          = 7;
    localparam int          MSI_G1_YEL_BIT   = 3;  // Bit 5 of G1
    localparam int          MSI_V5_YEL_BIT   = 0;  // Bit 8 of V5
    localparam logic [2:0]  MSI_K2_AISL      = 3'h7; // Bits 6-8 of K2
    // ==========================================================
    // Reset values
    localparam logic [31:0] MSI_RST_ZERO   = 32'h0000_0000;
    localparam logic [7:0]  MSI_ALL_ONES   = 8'hFF;
endpackage : msi_pkg

// >>> msi_persist.sv
// Purpose : Declares a condition after N consecutive qualified strobes
// Assumes : STB is a one-cycle pulse, one per frame
// Notes   : Clears after N consecutive frames without the condition
`timescale 1ns/1ps
`default_nettype none
module msi_persist
    import msi_pkg::*;
#(
    parameter int N = MSI_AISL_FRAMES
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic STB,
    input  wire logic COND,
    output var  logic STATE
);
    logic [3:0] cnt_reg;
    // ==========================================================
    // Frame counter toward a change of state
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_reg <= 4'h0;
            STATE   <= 1'b0;
        end else if (STB) begin
            if (COND == STATE) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg == 4'(N - 1)) begin
                cnt_reg <= 4'h0;
                STATE   <= COND;         // [RULE11]
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule : msi_persist
`default_nettype wire

// >>> msi_top.sv
// Purpose : Detects and inserts maintenance signals for one DS3 and one STS-1 port
// Assumes : Detector inputs come from framers, synchronous to CLK
// Notes   : Provisioning and status over classic Wishbone, one wait state
`timescale 1ns/1ps
`default_nettype none
module msi_top
    import msi_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output var  logic [31:0] WB_DAT_O,
    output var  logic        WB_ACK_O,
    // DS1 tributary data path
    input  wire logic [27:0] DS1_XCONN,
    input  wire logic [27:0] DS1_DATA_IN,
    input  wire logic        TEST_DATA,
    input  wire logic [27:0] DS1_LOS,
    input  wire logic [27:0] DS1_AIS_DET,
    input  wire logic [27:0] DS1_YEL_DET,
    output var  logic [27:0] DS1_DATA_OUT,
    // DS3 incoming detectors
    input  wire logic        DS3_LOS,
    input  wire logic        DS3_OOF,
    input  wire logic        DS3_FRAMED,
    input  wire logic        DS3_INFO_1010,
    input  wire logic        DS3_ALL_ONES,
    input  wire logic        DS3_IDLE_DET,
    output var  logic        DS3_FAIL_ALARM,
    output var  logic        DS3_AIS_IND,
    output var  logic        DS3_IDLE_IND,
    output var  logic        DS3_SEND_IDLE,
    // STS-1 incoming detectors and overhead
    input  wire logic        STS_LOS,
    input  wire logic        STS_LOF,
    input  wire logic        STS_LOP,
    input  wire logic        STS_AISP_DET,
    input  wire logic        STS_K2_STB,
    input  wire logic [7:0]  STS_K2,
    input  wire logic        STS_G1_STB,
    input  wire logic [7:0]  STS_G1,
    output var  logic        STS_AISL,
    output var  logic        STS_YEL,
    // STS-1 outgoing byte path
    input  wire logic [7:0]  STS_BYTE_IN,
    input  wire logic        STS_BYTE_AISABLE,
    output var  logic [7:0]  STS_BYTE_OUT,
    // VT1.5 detectors, overhead and byte path
    input  wire logic [27:0] VT_LOP,
    input  wire logic [27:0] VT_AISP_DET,
    input  wire logic        VT_V5_STB,
    input  wire logic [4:0]  VT_V5_TRIB,
    input  wire logic [7:0]  VT_V5,
    input  wire logic [7:0]  VT_BYTE_IN,
    input  wire logic [4:0]  VT_BYTE_TRIB,
    input  wire logic        VT_BYTE_AISABLE,
    output var  logic [7:0]  VT_BYTE_OUT,
    output var  logic [27:0] VT_AISP_SEND
);
    // ==========================================================
    // Provisioning and status state
    logic        idle_en_reg;
    logic [27:0] tsel_reg;
    logic [27:0] ovais_reg;
    logic [27:0] ovtst_reg;
    logic [27:0] pmen_reg;
    logic [27:0] srcsts_reg;
    logic [MSI_NST-1:0] evt_reg;
    logic [27:0] vtyel_reg;
    logic [27:0] d1yel_reg;
    logic        wb_hit;
    logic        wb_wr;
    logic [31:0] rd_next;
    logic [31:0] status_w;
    logic        ais_frm;
    logic        ais_unf;
    logic        ds3_ais;
    logic        ds3_inhibit;
    logic        ds3_fail;
    logic        sts_fail;
    logic        sts_fail_vt;
    logic        aisl_state;
    logic [27:0] vt_send;
    logic [27:0] ds1_ais_force;
    logic [27:0] ds1_test_force;

    // Byte-lane merge of write data into a register
    function automatic logic [31:0] msi_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : msi_merge

    // ==========================================================
    // Wishbone handshake: ack one cycle after the strobe, then drop
    assign wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr  = wb_hit & WB_WE_I;

    always_ff @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= MSI_RST_ZERO;
        end else begin
            WB_ACK_O <= wb_hit;
            WB_DAT_O <= wb_hit ? rd_next : MSI_RST_ZERO;
        end
    end

    // Provisioning registers, all disabled at reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            idle_en_reg <= 1'b0;                    // [RULE21]
            tsel_reg    <= MSI_RST_ZERO[27:0];      // [RULE21]
            ovais_reg   <= MSI_RST_ZERO[27:0];      // [RULE21]
            ovtst_reg   <= MSI_RST_ZERO[27:0];      // [RULE21]
            pmen_reg    <= MSI_RST_ZERO[27:0];
            srcsts_reg  <= MSI_RST_ZERO[27:0];
        end else if (wb_wr) begin
            case (WB_ADR_I)
                MSI_OFF_CTRL: begin
                    if (WB_SEL_I[0]) begin
                        idle_en_reg <= WB_DAT_I[MSI_CTRL_IDLE_EN];
                    end
                end
                MSI_OFF_TSEL: begin
                    tsel_reg <= 28'(msi_merge({4'h0, tsel_reg}, WB_DAT_I, WB_SEL_I));
                end
                MSI_OFF_OVAIS: begin
                    ovais_reg <= 28'(msi_merge({4'h0, ovais_reg}, WB_DAT_I, WB_SEL_I));
                end
                MSI_OFF_OVTST: begin
                    ovtst_reg <= 28'(msi_merge({4'h0, ovtst_reg}, WB_DAT_I, WB_SEL_I));
                end
                MSI_OFF_PMEN: begin
                    pmen_reg <= 28'(msi_merge({4'h0, pmen_reg}, WB_DAT_I, WB_SEL_I));
                end
                MSI_OFF_SRCSTS: begin
                    srcsts_reg <= 28'(msi_merge({4'h0, srcsts_reg}, WB_DAT_I, WB_SEL_I));
                end
                default: begin
                end
            endcase
        end
    end

    // Live status word
    always_comb begin
        status_w = MSI_RST_ZERO;
        status_w[MSI_ST_DS3_AIS]   = DS3_AIS_IND;
        status_w[MSI_ST_DS3_IDLE]  = DS3_IDLE_IND;
        status_w[MSI_ST_AIS_FRM]   = ais_frm;
        status_w[MSI_ST_AIS_UNF]   = ais_unf;
        status_w[MSI_ST_AISL]      = STS_AISL;
        status_w[MSI_ST_STS_YEL]   = STS_YEL;
        status_w[MSI_ST_SEND_IDLE] = DS3_SEND_IDLE;
    end

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        case (WB_ADR_I)
            MSI_OFF_CTRL:   rd_next = {31'h0, idle_en_reg};
            MSI_OFF_TSEL:   rd_next = {4'h0, tsel_reg};
            MSI_OFF_OVAIS:  rd_next = {4'h0, ovais_reg};
            MSI_OFF_OVTST:  rd_next = {4'h0, ovtst_reg};
            MSI_OFF_PMEN:   rd_next = {4'h0, pmen_reg};
            MSI_OFF_SRCSTS: rd_next = {4'h0, srcsts_reg};
            MSI_OFF_STAT:   rd_next = status_w;                 // [RULE8]
            MSI_OFF_EVT:    rd_next = {25'h0, evt_reg};
            MSI_OFF_VTYEL:  rd_next = {4'h0, vtyel_reg};
            MSI_OFF_D1YEL:  rd_next = {4'h0, d1yel_reg};
            default:        rd_next = MSI_RST_ZERO;
        endcase
    end

    // Sticky events, write one to clear, a new event wins over the clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            evt_reg <= '0;
        end else begin
            for (int k = 0; k < MSI_NST; k++) begin
                if (status_w[k]) begin
                    evt_reg[k] <= 1'b1;                          // [RULE8]
                end else if (wb_wr && WB_ADR_I == MSI_OFF_EVT && WB_SEL_I[0] && WB_DAT_I[k]) begin
                    evt_reg[k] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // DS3 AIS and idle detection
    assign ais_frm     = DS3_FRAMED & DS3_INFO_1010;            // [RULE9]
    assign ais_unf     = ~DS3_FRAMED & DS3_ALL_ONES;            // [RULE9]
    assign ds3_ais     = ais_frm | ais_unf;
    assign ds3_inhibit = ds3_ais | DS3_IDLE_DET;
    assign ds3_fail    = DS3_LOS | DS3_OOF | ds3_ais;           // [RULE4]

    always_ff @(posedge CLK) begin
        if (RST) begin
            DS3_AIS_IND    <= 1'b0;
            DS3_IDLE_IND   <= 1'b0;
            DS3_FAIL_ALARM <= 1'b0;
            DS3_SEND_IDLE  <= 1'b0;
        end else begin
            DS3_AIS_IND    <= ds3_ais;                           // [RULE8]
            DS3_IDLE_IND   <= DS3_IDLE_DET;                      // [RULE8]
            DS3_FAIL_ALARM <= (DS3_LOS | DS3_OOF) & ~ds3_inhibit; // [RULE7]
            DS3_SEND_IDLE  <= idle_en_reg & ~(|DS1_XCONN);       // [RULE2]
        end
    end

    // ==========================================================
    // STS-1 line AIS, needs five consecutive K2 frames
    msi_persist #(
        .N     (MSI_AISL_FRAMES)
    ) u_aisl (
        .CLK   (CLK),
        .RST   (RST),
        .STB   (STS_K2_STB),
        .COND  (STS_K2[2:0] == MSI_K2_AISL),                   // [RULE10]
        .STATE (aisl_state)
    );

    assign sts_fail    = STS_LOS | STS_LOF | aisl_state | STS_LOP;  // [RULE3]
    assign sts_fail_vt = sts_fail | STS_AISP_DET;                   // [RULE14]

    // STS-1 status and yellow capture
    always_ff @(posedge CLK) begin
        if (RST) begin
            STS_AISL <= 1'b0;
            STS_YEL  <= 1'b0;
        end else begin
            STS_AISL <= aisl_state;
            if (STS_G1_STB) begin
                STS_YEL <= STS_G1[MSI_G1_YEL_BIT];               // [RULE18]
            end
        end
    end

    // Outgoing STS-1 bytes: only pointer and SPE bytes are forced,
    // line overhead passes, so line AIS is never generated here
    always_ff @(posedge CLK) begin
        if (RST) begin
            STS_BYTE_OUT <= 8'h00;
        end else if (sts_fail && STS_BYTE_AISABLE) begin
            STS_BYTE_OUT <= MSI_ALL_ONES;                        // [RULE13] [RULE12]
        end else begin
            STS_BYTE_OUT <= STS_BYTE_IN;
        end
    end

    // ==========================================================
    // Per-tributary decisions
    genvar gi;
    generate
        for (gi = 0; gi < MSI_NTRIB; gi++) begin : g_trib
            logic src_fail;
            // VT path AIS on STS failure or this VT's pointer loss
            assign vt_send[gi] = sts_fail_vt | VT_LOP[gi];       // [RULE14] [RULE15]
            // Source failure by where the tributary comes from
            assign src_fail = srcsts_reg[gi] ? (VT_LOP[gi] | VT_AISP_DET[gi] | sts_fail_vt)
                                             : (DS1_LOS[gi] | DS1_AIS_DET[gi] | ds3_fail); // [RULE17] [RULE4]
            assign ds1_ais_force[gi]  = ~DS1_XCONN[gi] | ovais_reg[gi]
                                        | (src_fail & ~ovtst_reg[gi] & ~tsel_reg[gi]); // [RULE1] [RULE6] [RULE3]
            assign ds1_test_force[gi] = ovtst_reg[gi] | tsel_reg[gi];               // [RULE5] [RULE6]

            // Outgoing DS1 bit and DS1 yellow report
            always_ff @(posedge CLK) begin
                if (RST) begin
                    DS1_DATA_OUT[gi] <= 1'b1;
                    d1yel_reg[gi]    <= 1'b0;
                end else begin
                    if (ds1_ais_force[gi]) begin
                        DS1_DATA_OUT[gi] <= 1'b1;                  // [RULE1] [RULE17]
                    end else if (ds1_test_force[gi]) begin
                        DS1_DATA_OUT[gi] <= TEST_DATA;             // [RULE5]
                    end else begin
                        DS1_DATA_OUT[gi] <= DS1_DATA_IN[gi];
                    end
                    d1yel_reg[gi] <= DS1_YEL_DET[gi] & pmen_reg[gi]; // [RULE20]
                end
            end

            // VT yellow capture, reported whenever received
            always_ff @(posedge CLK) begin
                if (RST) begin
                    vtyel_reg[gi] <= 1'b0;
                end else if (VT_V5_STB && VT_V5_TRIB == 5'(gi)) begin
                    vtyel_reg[gi] <= VT_V5[MSI_V5_YEL_BIT];        // [RULE19] [RULE20]
                end
            end
        end
    endgenerate

    // ==========================================================
    // VT path AIS flags and outgoing VT bytes
    always_ff @(posedge CLK) begin
        if (RST) begin
            VT_AISP_SEND <= MSI_RST_ZERO[27:0];
            VT_BYTE_OUT  <= 8'h00;
        end else begin
            VT_AISP_SEND <= vt_send;
            if (VT_BYTE_AISABLE && VT_BYTE_TRIB < 5'(MSI_NTRIB) && vt_send[VT_BYTE_TRIB]) begin
                VT_BYTE_OUT <= MSI_ALL_ONES;                     // [RULE16]
            end else begin
                VT_BYTE_OUT <= VT_BYTE_IN;
            end
        end
    end
endmodule : msi_top
`default_nettype wire

// >>> msi_props.sv
// Purpose: Port checks of msi_top
// Assumes: Outputs other than STS_AISL lag inputs one edge
// Notes: Bound at the foot
`timescale 1ns/1ps
`default_nettype none
module msi_props
    import msi_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [27:0] DS1_XCONN,
    input wire logic [27:0] DS1_DATA_OUT,
    input wire logic        DS3_FRAMED,
    input wire logic        DS3_INFO_1010,
    input wire logic        DS3_ALL_ONES,
    input wire logic        DS3_IDLE_DET,
    input wire logic        DS3_FAIL_ALARM,
    input wire logic        DS3_AIS_IND,
    input wire logic        DS3_IDLE_IND,
    input wire logic        DS3_SEND_IDLE,
    input wire logic        STS_LOS,
    input wire logic        STS_AISP_DET,
    input wire logic        STS_K2_STB,
    input wire logic [7:0]  STS_K2,
    input wire logic        STS_G1_STB,
    input wire logic [7:0]  STS_G1,
    input wire logic        STS_AISL,
    input wire logic        STS_YEL,
    input wire logic        STS_BYTE_AISABLE,
    input wire logic [7:0]  STS_BYTE_OUT,
    input wire logic [27:0] VT_LOP,
    input wire logic [27:0] VT_AISP_SEND
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic [2:0] run_reg;
    // ==========================================================
    // Run of consecutive frames with K2 bits 6-8 all ones
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_reg <= 3'h0;
        end else if (STS_K2_STB) begin
            run_reg <= (STS_K2[2:0] != 3'h7) ? 3'h0 : (run_reg == 3'h7) ? run_reg : run_reg + 3'h1;
        end
    end
    // ==========================================================
    // Assertions
    a_unconn_idle: assert property (!$past(RST) |-> (~$past(DS1_XCONN) & ~DS1_DATA_OUT) == 28'h0)
        else $error("unconnected not ones");
    a_idle_send: assert property (DS3_SEND_IDLE |-> $past(DS1_XCONN) == 28'h0)
        else $error("DS3 idle with connected trib");
    a_alarm_inhibit: assert property ((DS3_AIS_IND || DS3_IDLE_IND) |-> !DS3_FAIL_ALARM)
        else $error("failure alarm during DS3 AIS or idle");
    a_ais_status: assert property (!$past(RST) |-> DS3_AIS_IND == $past(DS3_FRAMED ? DS3_INFO_1010 : DS3_ALL_ONES))
        else $error("DS3 AIS status wrong");
    a_idle_status: assert property (!$past(RST) |-> DS3_IDLE_IND == $past(DS3_IDLE_DET))
        else $error("DS3 idle status wrong");
    a_aisl_early: assert property ($rose(STS_AISL) |-> run_reg >= 3'h5)
        else $error("line AIS before five frames");
    a_aisl_enter: assert property (run_reg == 3'h5 && $past(run_reg) == 3'h4 |-> ##[0:2] STS_AISL)
        else $error("line AIS not entered");
    a_sts_yellow: assert property (STS_G1_STB |=> STS_YEL == $past(STS_G1[3]))
        else $error("STS yellow not G1 bit 5");
    a_path_ones: assert property (!$past(RST) && $past(STS_BYTE_AISABLE && STS_LOS) |-> STS_BYTE_OUT == 8'hFF)
        else $error("path AIS byte not ones");
    a_vt_all: assert property (!$past(RST) && $past(STS_LOS || STS_AISP_DET) |-> VT_AISP_SEND == 28'hFFFFFFF)
        else $error("VT AIS not on all");
    a_vt_lop: assert property (!$past(RST) |-> ($past(VT_LOP) & ~VT_AISP_SEND) == 28'h0)
        else $error("VT loss of pointer without AIS");
    c_aisl: cover property ($rose(STS_AISL));
    c_idle: cover property ($rose(DS3_SEND_IDLE));
    c_alarm: cover property ($rose(DS3_FAIL_ALARM));
endmodule : msi_props
bind msi_top msi_props u_props (.*);
`default_nettype wire

// >>> msi_line_src.sv
// Purpose: Upstream STS-1 element sending K2 and G1 once a frame
// Assumes: A frame is four clocks
// Notes: Overhead bytes are garbage away from their strobes
`timescale 1ns/1ps
`default_nettype none
module msi_line_src (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [2:0] K2_VAL,
    input  wire logic       YEL,
    output var  logic       K2_STB,
    output var  logic [7:0] K2,
    output var  logic       G1_STB,
    output var  logic [7:0] G1
);
    logic [1:0] ph_reg;
    // Frame phase, strobes, overhead; idle bytes flip
    always_ff @(posedge CLK) begin
        ph_reg <= RST ? 2'h0 : ph_reg + 2'h1;
        K2_STB <= !RST && ph_reg == 2'h3;
        G1_STB <= !RST && ph_reg == 2'h1;
        K2 <= RST ? 8'h00 : (ph_reg == 2'h3) ? {5'h00, K2_VAL} : ~K2;
        G1 <= RST ? 8'h00 : (ph_reg == 2'h1) ? {4'h0, YEL, 3'h0} : ~G1;
    end
endmodule : msi_line_src
`default_nettype wire

// >>> tb_maintenance_signal_insert.sv
// Purpose: Self-checking bench of msi_top
// Assumes: Wishbone answers after one wait state
// Notes: Detectors driven by the bench
`timescale 1ns/1ps
`default_nettype none
module tb_maintenance_signal_insert
    import msi_pkg::*;
;
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h seen %0h", n, e, a); end end
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, td = 1'b0, ack;
    logic [7:0]  adr = 8'h00, sin = 8'h00, vin = 8'h00, v5 = 8'h00, k2, g1, sout, vout;
    logic [31:0] wd = 32'h0, dato, rd;
    logic [27:0] xc = 28'h0, din = 28'h0, los = 28'h0, aisd = 28'h0, yel = 28'h0, vlop = 28'h0, vap = 28'h0, d1o, vsnd;
    logic        d3los = 1'b0, d3oof = 1'b0, d3frm = 1'b0, d3p = 1'b0, d3one = 1'b0, d3idl = 1'b0;
    logic        slos = 1'b0, saisp = 1'b0, sab = 1'b0, vab = 1'b0, v5s = 1'b0, g1y = 1'b0;
    logic        alrm, aisi, idli, sidl, aisl, syel, k2s, g1s;
    logic [4:0]  v5t = 5'h0, vt = 5'h0;
    logic [2:0]  k2v = 3'h0;
    int          fail_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    // Design and upstream element
    msi_top dut_u (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(dato), .WB_ACK_O(ack), .DS1_XCONN(xc), .DS1_DATA_IN(din),
        .TEST_DATA(td), .DS1_LOS(los), .DS1_AIS_DET(aisd), .DS1_YEL_DET(yel), .DS1_DATA_OUT(d1o),
        .DS3_LOS(d3los), .DS3_OOF(d3oof), .DS3_FRAMED(d3frm), .DS3_INFO_1010(d3p), .DS3_ALL_ONES(d3one),
        .DS3_IDLE_DET(d3idl), .DS3_FAIL_ALARM(alrm), .DS3_AIS_IND(aisi), .DS3_IDLE_IND(idli),
        .DS3_SEND_IDLE(sidl), .STS_LOS(slos), .STS_LOF(1'b0), .STS_LOP(1'b0), .STS_AISP_DET(saisp),
        .STS_K2_STB(k2s), .STS_K2(k2), .STS_G1_STB(g1s), .STS_G1(g1), .STS_AISL(aisl), .STS_YEL(syel),
        .STS_BYTE_IN(sin), .STS_BYTE_AISABLE(sab), .STS_BYTE_OUT(sout), .VT_LOP(vlop), .VT_AISP_DET(vap),
        .VT_V5_STB(v5s), .VT_V5_TRIB(v5t), .VT_V5(v5), .VT_BYTE_IN(vin), .VT_BYTE_TRIB(vt),
        .VT_BYTE_AISABLE(vab), .VT_BYTE_OUT(vout), .VT_AISP_SEND(vsnd));
    msi_line_src src_u (.CLK(clk), .RST(rst), .K2_VAL(k2v), .YEL(g1y), .K2_STB(k2s), .K2(k2),
        .G1_STB(g1s), .G1(g1));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk);
            while (k2s !== 1'b1) @(posedge clk);
        end
    endtask : frames
    // Wishbone cycle held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (ack !== 1'b1 && t < 20) begin
            @(posedge clk);
            t++;
        end
        if (t >= 20) fail_count++;
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            `CHK("prov reg", 32'h0, rd)
        end
        wb(1'b0, 8'h3C, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("idle out", 28'hFFFFFFF, d1o)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ds1;
        xc <= 28'hFFFFFEF;
        din <= 28'h5A5A5A5;
        los <= 28'h1;
        aisd <= 28'h2;
        tick(2);
        `CHK("ds1 fail", 28'h5A5A5B7, d1o)
        los <= 28'h0;
        aisd <= 28'h0;
        d3oof <= 1'b1;
        tick(2);
        `CHK("ds3 fail", 28'hFFFFFFF, d1o)
        d3oof <= 1'b0;
        xc <= 28'hFFFFFFF;
        din <= 28'h0;
        td <= 1'b1;
        wb(1'b1, MSI_OFF_OVAIS, 32'h100);
        wb(1'b1, MSI_OFF_OVTST, 32'h8);
        wb(1'b1, MSI_OFF_TSEL, 32'h40);
        tick(2);
        `CHK("test one", 28'h0000148, d1o)
        td <= 1'b0;
        tick(2);
        `CHK("test zero", 28'h0000100, d1o)
        wb(1'b1, MSI_OFF_OVAIS, 32'h0);
        wb(1'b1, MSI_OFF_SRCSTS, 32'h600);
        vlop <= 28'h200;
        vap <= 28'h400;
        tick(2);
        `CHK("vt fail", 28'h0000600, d1o)
        vlop <= 28'h0;
        vap <= 28'h0;
        $display("t_ds1 done");
    endtask : t_ds1
    task automatic t_ds3;
        xc <= 28'h0;
        wb(1'b1, MSI_OFF_CTRL, 32'h1);
        tick(2);
        `CHK("send idle", 1'b1, sidl)
        xc <= 28'h8000000;
        d3los <= 1'b1;
        tick(2);
        `CHK("no idle", 1'b0, sidl)
        `CHK("alarm", 1'b1, alrm)
        d3idl <= 1'b1;
        tick(2);
        `CHK("idle inhibit", 2'b01, {alrm, idli})
        d3idl <= 1'b0;
        d3frm <= 1'b1;
        d3p <= 1'b1;
        tick(2);
        `CHK("ais inhibit", 2'b01, {alrm, aisi})
        wb(1'b0, MSI_OFF_STAT, 32'h0);
        `CHK("framed ais", 2'b01, rd[3:2])
        d3frm <= 1'b0;
        d3p <= 1'b0;
        d3one <= 1'b1;
        tick(2);
        wb(1'b0, MSI_OFF_STAT, 32'h0);
        `CHK("unframed ais", 2'b10, rd[3:2])
        wb(1'b0, MSI_OFF_EVT, 32'h0);
        `CHK("events", 2'b11, rd[1:0])
        d3one <= 1'b0;
        d3los <= 1'b0;
        $display("t_ds3 done");
    endtask : t_ds3
    task automatic t_aisl;
        k2v <= 3'h6;
        frames(6);
        tick(2);
        `CHK("k2 partial", 1'b0, aisl)
        k2v <= 3'h7;
        frames(4);
        tick(2);
        `CHK("four frames", 1'b0, aisl)
        frames(1);
        tick(2);
        `CHK("five frames", 1'b1, aisl)
        sin <= 8'h3C;
        tick(2);
        `CHK("no aisl sent", 8'h3C, sout)
        k2v <= 3'h0;
        frames(6);
        $display("t_aisl done");
    endtask : t_aisl
    task automatic t_sts;
        sab <= 1'b1;
        slos <= 1'b1;
        tick(2);
        `CHK("path ais", 8'hFF, sout)
        `CHK("vt all", 28'hFFFFFFF, vsnd)
        slos <= 1'b0;
        vlop <= 28'h8;
        vab <= 1'b1;
        vt <= 5'h3;
        vin <= 8'h21;
        tick(2);
        `CHK("vt lop", 28'h8, vsnd)
        `CHK("vt ones", 8'hFF, vout)
        vt <= 5'h4;
        tick(2);
        `CHK("vt pass", 8'h21, vout)
        g1y <= 1'b1;
        tick(10);
        `CHK("sts yel", 1'b1, syel)
        v5t <= 5'h6;
        v5 <= 8'h01;
        v5s <= 1'b1;
        tick(1);
        v5s <= 1'b0;
        yel <= 28'h3;
        wb(1'b1, MSI_OFF_PMEN, 32'h1);
        wb(1'b0, MSI_OFF_VTYEL, 32'h0);
        `CHK("vt yel", 32'h40, rd)
        wb(1'b0, MSI_OFF_D1YEL, 32'h0);
        `CHK("ds1 yel", 32'h1, rd)
        $display("t_sts done");
    endtask : t_sts
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // Main sequence and watchdog
    initial begin
        tick(3);
        rst <= 1'b0;
        t_reset();
        t_ds1();
        t_ds3();
        t_aisl();
        t_sts();
        end_of_test();
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule : tb_maintenance_signal_insert
`default_nettype wire
